// ==== nss_core.sv ====
// Purpose: Executes swap and conditional skip instructions.
// Assumes: The core holds off a new instruction during the dummy cycle.
// Notes: No status flag port exists, so flags are never touched.
`timescale 1ns/1ps
module nss_core (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Instruction
    input wire nss_pkg::nss_instr_s i_instr,
    // Results
    output logic [7:0] o_acc,
    output logic o_acc_we,
    output logic [11:0] o_pc,
    output logic o_skip_taken,
    output logic o_dummy,
    output logic o_busy
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    nss_pkg::nss_state_s st;
    nss_pkg::nss_state_s next_st;
    logic skip;
    logic take_now;

    // The reset image is a constant, so the asynchronous branch loads
    // nothing but fixed values.
    localparam nss_pkg::nss_state_s ST_RESET = '{
        state: nss_pkg::NSS_ST_EXEC,
        acc: nss_pkg::ACC_RESET,
        pc: nss_pkg::PC_RESET,
        skip_taken: 1'b0,
        dummy: 1'b0,
        acc_we: 1'b0
    };

    nss_skip_eval u_eval (
        .i_op(i_instr.op),
        .i_data(i_instr.mem_data),
        .i_bit_sel(i_instr.bit_sel),
        .o_skip(skip)
    );

    function automatic logic [7:0] swap_nib(input logic [7:0] d);
        swap_nib = {d[3:0], d[nss_pkg::NIB_HI:nss_pkg::NIB_LO]};
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // The skipped opcode is fetched but never executed, so the counter
    // steps twice across the two cycles.
    always_comb begin
        next_st = st;
        next_st.skip_taken = 1'b0;
        next_st.dummy = 1'b0;
        next_st.acc_we = 1'b0;
        case (st.state)
            nss_pkg::NSS_ST_EXEC: begin
                if (i_instr.valid) begin
                    next_st.pc = st.pc + nss_pkg::PC_STEP;
                    case (i_instr.op)
                        nss_pkg::NSS_OP_SWAP: begin
                            next_st.acc = swap_nib(i_instr.mem_data); // [RL1]
                            next_st.acc_we = 1'b1; // [RL2]
                        end
                        nss_pkg::NSS_OP_CSKZ: begin
                            next_st.acc = i_instr.mem_data; // [RL5]
                            next_st.acc_we = 1'b1;
                        end
                        default: begin
                            next_st.acc = st.acc;
                        end
                    endcase
                    if (skip) begin
                        next_st.skip_taken = 1'b1;
                        next_st.state = nss_pkg::NSS_ST_DUMMY; // [RL4]
                    end
                end
            end
            nss_pkg::NSS_ST_DUMMY: begin
                next_st.dummy = 1'b1; // [RL8]
                next_st.pc = st.pc + nss_pkg::PC_STEP; // [RL8]
                next_st.state = nss_pkg::NSS_ST_EXEC;
            end
            default: begin
                next_st.state = nss_pkg::NSS_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_acc = st.acc;
    assign o_acc_we = st.acc_we;
    assign o_pc = st.pc;
    assign o_skip_taken = st.skip_taken;
    assign o_dummy = st.dummy;
    assign o_busy = (st.state == nss_pkg::NSS_ST_DUMMY);

    // The instruction input is only taken in the execute state; whatever
    // is offered during the dummy cycle is ignored.
    assign take_now = (st.state == nss_pkg::NSS_ST_EXEC) && i_instr.valid;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Every check stands down while reset is high, so the reset image is
    // judged by the bench rather than here.
    a_swap_result: assert property ( // [RL1]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_SWAP) |=>
        (o_acc[3:0] == $past(i_instr.mem_data[7:4])) &&
        (o_acc[7:4] == $past(i_instr.mem_data[3:0])))
        else $error("swap result wrong");

    a_swap_no_skip: assert property ( // [RL2]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_SWAP) |=>
        (!o_skip_taken && !o_busy && o_acc_we))
        else $error("swap misbehaved");

    a_we_source: assert property ( // [RL2]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_acc_we |-> $past(take_now) &&
        ($past(i_instr.op) == nss_pkg::NSS_OP_SWAP ||
         $past(i_instr.op) == nss_pkg::NSS_OP_CSKZ))
        else $error("acc written by wrong op");

    a_skz_zero: assert property ( // [RL3]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_SKZ) |=>
        (o_skip_taken == ($past(i_instr.mem_data) == 8'h00)))
        else $error("skip if zero decision wrong");

    a_skz_keep_acc: assert property ( // [RL3]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_SKZ) |=>
        (!o_acc_we && $stable(o_acc)))
        else $error("skip if zero wrote acc");

    a_skip_source: assert property ( // [RL3]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_skip_taken |-> $past(take_now) &&
        ($past(i_instr.op) != nss_pkg::NSS_OP_SWAP) &&
        ($past(i_instr.op) != nss_pkg::NSS_OP_NONE))
        else $error("skip without a skip op");

    a_skip_two_cyc: assert property ( // [RL4]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_skip_taken |->
        o_busy ##1 (o_dummy && !o_busy))
        else $error("skip did not take two cycles");

    a_skip_pulse: assert property ( // [RL4]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_skip_taken |=> !o_skip_taken)
        else $error("skip flag longer than one cycle");

    a_busy_one_cyc: assert property ( // [RL4]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_busy |=> !o_busy)
        else $error("dummy cycle longer than one cycle");

    a_busy_source: assert property ( // [RL4]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_busy |-> o_skip_taken)
        else $error("dummy cycle without a skip");

    a_none_quiet: assert property ( // [RL4]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_NONE) |=>
        (!o_skip_taken && !o_busy && !o_acc_we))
        else $error("plain op skipped or wrote acc");

    a_cskz_load: assert property ( // [RL5]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_CSKZ) |=>
        o_acc_we && (o_acc == $past(i_instr.mem_data)) &&
        (o_skip_taken == ($past(i_instr.mem_data) == 8'h00)))
        else $error("copy skip wrong");

    a_bit_test: assert property ( // [RL6]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_BSKZ) |=>
        (o_skip_taken == !$past(i_instr.mem_data[i_instr.bit_sel])))
        else $error("bit test decision wrong");

    a_bit_keep_acc: assert property ( // [RL6]
        @(posedge i_sys_clk) disable iff (i_reset)
        (take_now && i_instr.op == nss_pkg::NSS_OP_BSKZ) |=>
        (!o_acc_we && $stable(o_acc)))
        else $error("bit test wrote acc");

    a_acc_stable: assert property ( // [RL7]
        @(posedge i_sys_clk) disable iff (i_reset)
        !o_acc_we |-> ($stable(o_acc) || $past(i_reset)))
        else $error("acc changed without write");

    a_dummy_nop: assert property ( // [RL8]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_busy |=> !o_acc_we && !o_skip_taken && $stable(o_acc) &&
        (o_pc == $past(o_pc) + nss_pkg::PC_STEP))
        else $error("dummy cycle not a no-op");

    a_dummy_after_busy: assert property ( // [RL8]
        @(posedge i_sys_clk) disable iff (i_reset)
        o_dummy |-> $past(o_busy))
        else $error("dummy flag without a dummy cycle");

    a_pc_step: assert property ( // [RL8]
        @(posedge i_sys_clk) disable iff (i_reset)
        take_now |=> (o_pc == $past(o_pc) + nss_pkg::PC_STEP))
        else $error("counter did not step");

endmodule

// ==== nss_pkg.sv ====
// Purpose: Shared constants and types for the nibble swap and skip unit.
// Assumes: One instruction is presented per machine cycle by the core.
// Notes: The unit owns the accumulator; data memory is only read.
// Function
// [RL1] Swap places the byte's upper nibble in acc[3:0] and lower in acc[7:4].
// [RL2] Swap never writes data memory; only the accumulator changes.
// [RL3] Skip-if-zero discards the next instruction when the byte is zero.
// [RL4] A taken skip spends a dummy cycle so the instruction takes two cycles.
// [RL5] Copy-skip-if-zero always loads the byte into acc and skips if zero.
// [RL6] Bit-test skip skips when the selected bit is zero, else proceeds.
// [RL7] None of these instructions alters any status flag.
// [RL8] The dummy cycle writes nothing and the counter passes the skipped op.
package nss_pkg;

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int BIT_SEL_W = 3;
    localparam int NIB_HI = 7;
    localparam int NIB_LO = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [11:0] PC_STEP = 12'h001;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        NSS_OP_NONE = 3'b000,
        NSS_OP_SWAP = 3'b001,
        NSS_OP_SKZ = 3'b010,
        NSS_OP_CSKZ = 3'b011,
        NSS_OP_BSKZ = 3'b100
    } nss_op_e;

    typedef enum logic [0:0] {
        NSS_ST_EXEC = 1'b0,
        NSS_ST_DUMMY = 1'b1
    } nss_state_e;

    typedef struct packed {
        logic valid;
        nss_op_e op;
        logic [7:0] mem_data;
        logic [2:0] bit_sel;
    } nss_instr_s;

    typedef struct packed {
        nss_state_e state;
        logic [7:0] acc;
        logic [11:0] pc;
        logic skip_taken;
        logic dummy;
        logic acc_we;
    } nss_state_s;

endpackage

// ==== nss_skip_eval.sv ====
// Purpose: Decides whether a conditional skip instruction skips.
// Assumes: Inputs come unregistered from the caller's instruction port.
// Notes: Purely combinational.
`timescale 1ns/1ps
module nss_skip_eval (
    // Instruction
    input wire nss_pkg::nss_op_e i_op,
    input wire logic [7:0] i_data,
    input wire logic [2:0] i_bit_sel,
    // Result
    output logic o_skip
);

    always_comb begin
        case (i_op)
            nss_pkg::NSS_OP_SKZ: o_skip = (i_data == 8'h00); // [RL3]
            nss_pkg::NSS_OP_CSKZ: o_skip = (i_data == 8'h00); // [RL5]
            nss_pkg::NSS_OP_BSKZ: o_skip = ~i_data[i_bit_sel]; // [RL6]
            default: o_skip = 1'b0;
        endcase
    end

endmodule

// ==== nss_core_bench.sv ====
// Purpose: Self-checking bench for the nibble swap and skip unit.
// Assumes: Outputs settle well before the falling edge that samples them.
// Notes: A model of acc and pc kept in integers predicts every result.
`timescale 1ns/1ps
module nss_core_bench;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    nss_pkg::nss_instr_s i_instr = '0;
    logic [7:0] o_acc;
    logic o_acc_we;
    logic [11:0] o_pc;
    logic o_skip_taken;
    logic o_dummy;
    logic o_busy;
    int fail_count = 0;
    int samples_checked = 0;
    int acc = 0;
    int pc = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    nss_core DUT (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_instr(i_instr),
        .o_acc(o_acc),
        .o_acc_we(o_acc_we),
        .o_pc(o_pc),
        .o_skip_taken(o_skip_taken),
        .o_dummy(o_dummy),
        .o_busy(o_busy)
    );

    task automatic chk(input string n, input logic [11:0] seen,
                       input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic close_out;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // One instruction, plus the dummy cycle when it skips
    // ----------------------------------------
    task automatic step(input logic [2:0] op, input logic [7:0] d,
                        input logic [2:0] b);
        bit skip;
        skip = ((op == 3'd2 || op == 3'd3) && d == 8'h00);
        skip = skip || (op == 3'd4 && !d[b]);
        i_instr = '{1'b1, nss_pkg::nss_op_e'(op), d, b};
        if (op == 3'd1) acc = {d[3:0], d[7:4]};
        if (op == 3'd3) acc = d;
        pc = (pc + 1) % 4096;
        @(negedge i_sys_clk);
        chk("acc", o_acc, acc);
        chk("acc_we", o_acc_we, op == 3'd1 || op == 3'd3);
        chk("skip", o_skip_taken, skip);
        chk("busy", o_busy, skip);
        chk("pc", o_pc, pc);
        chk("dummy", o_dummy, 0);
        if (skip) begin
            // A swap offered now must be refused, so acc must not move.
            i_instr = '{1'b1, nss_pkg::NSS_OP_SWAP, 8'($urandom), b};
            @(negedge i_sys_clk);
            pc = (pc + 1) % 4096;
            chk("dummy", o_dummy, 1);
            chk("busy", o_busy, 0);
            chk("acc_we", o_acc_we, 0);
            chk("acc", o_acc, acc);
            chk("pc", o_pc, pc);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'he8fe));
        repeat (3) @(negedge i_sys_clk);
        chk("acc", o_acc, 0);
        chk("pc", o_pc, 0);
        i_reset = 1'b0;
        step(3'd1, 8'hA5, 3'd0);
        step(3'd2, 8'h00, 3'd0);
        step(3'd2, 8'h80, 3'd0);
        step(3'd3, 8'h00, 3'd0);
        step(3'd3, 8'h01, 3'd0);
        for (int b = 0; b < 8; b++) begin
            step(3'd4, 8'h01 << b, 3'(b));
            step(3'd4, ~(8'h01 << b), 3'(b));
        end
        repeat (300) begin
            step(3'($urandom % 5),
                 ($urandom % 4 == 0) ? 8'h00 : 8'($urandom), 3'($urandom));
        end
        close_out();
    end

    // A hang is cut off well past the roughly 400 cycles the tests need.
    initial begin
        #(25 * 4000);
        fail_count++;
        close_out();
    end
endmodule
